// ==== hdl/csc_pkg.sv ====
// Constants and types shared by the clock source and start-up controller.
package csc_pkg;
    // Clock and oscillator rates; internal oscillators are enable dividers.
    localparam int MCLK_HZ = 25000000;
    localparam int WDT_OSC_HZ = 128000;
    localparam int RC8_HZ = 8000000;
    localparam int RC4_HZ = 4000000;
    localparam logic [7:0] WDT_DIV = 8'(MCLK_HZ / WDT_OSC_HZ);
    localparam logic [7:0] RC8_DIV = 8'(MCLK_HZ / RC8_HZ);
    localparam logic [7:0] RC4_DIV = 8'(MCLK_HZ / RC4_HZ);
    // Source select codes as read from the fuses (zero means programmed).
    localparam logic [3:0] SRC_EXT = 4'h0;
    localparam logic [3:0] SRC_RC4 = 4'h2;
    localparam logic [3:0] SRC_RC8 = 4'h4;
    localparam logic [3:0] SRC_WDT = 4'h6;
    localparam int SRC_XTAL_BIT = 3;
    localparam logic [1:0] SUT_RESERVED = 2'h3;
    // Start-up lengths in selected-clock cycles, fixed reset part too; fuse sync in system clock cycles.
    localparam logic [16:0] SU_SHORT_CYC = 17'h00006;
    localparam logic [16:0] SU_MID_CYC = 17'h00102;
    localparam logic [16:0] SU_1K_CYC = 17'h00400;
    localparam logic [16:0] DLY_FIX_CYC = 17'h0000E;
    localparam logic [16:0] FUSE_SYNC_CYC = 17'h00002;
    // Watchdog-timed reset delay times, in ms as printed.
    localparam real DLY_SHORT_MS = 4.1;
    localparam real DLY_LONG_MS = 65.0;
    // Prescale after fuse capture, log2 of the divide ratio.
    localparam logic [3:0] PSC_DIV8 = 4'h3;
    localparam logic [3:0] PSC_DIV1 = 4'h0;
    localparam logic [3:0] PSC_MAX = 4'h8;
    // APB map and field positions.
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_STAT = 12'h004;
    localparam logic [11:0] ADDR_PSC = 12'h008;
    localparam int CTRL_MODE_LSB = 0;
    localparam int STAT_SRC_LSB = 0;
    localparam int STAT_SUT_LSB = 4;
    localparam int STAT_DIV8_BIT = 6;
    localparam int STAT_RUN_BIT = 7;
    localparam int STAT_ERR_BIT = 8;
    localparam int STAT_STATE_LSB = 9;
    localparam logic [1:0] CTRL_RESET = 2'h0;
    // Start-up length, reset delay, sleep mode and sequencer state choices.
    typedef enum logic [1:0] {SU_SHORT = 2'h0, SU_MID = 2'h1, SU_1K = 2'h2,
        SU_16K = 2'h3} csc_su_t;
    typedef enum logic [1:0] {DLY_NONE = 2'h0, DLY_SHORT = 2'h1,
        DLY_LONG = 2'h2} csc_dly_t;
    typedef enum logic [1:0] {SLP_IDLE = 2'h0, SLP_PDOWN = 2'h1,
        SLP_STDBY = 2'h2} csc_sleep_t;
    typedef enum logic [6:0] {ST_FUSE = 7'h01, ST_SU = 7'h02,
        ST_FIX = 7'h04, ST_WDT = 7'h08, ST_RUN = 7'h10, ST_SLEEP = 7'h20,
        ST_HALT = 7'h40} csc_state_t;
endpackage : csc_pkg

// ==== hdl/csc_top.sv ====
// Clock source selection, start-up sequencing and clock domain gating.
//
// The APB slave port and the register addresses were decided locally.
`timescale 1ns/100ps
module csc_top
    import csc_pkg::*;
#(
    parameter logic [16:0] SU_LONG_CYC = 17'h04000,
    parameter logic [16:0] WDT_SHORT_CYC = 17'h01000,
    parameter logic [16:0] WDT_LONG_CYC = 17'h10000
)
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [3:0] clock_source_select,
    input wire logic [1:0] startup_time_select,
    input wire logic divide_by_eight_fuse,
    input wire logic amplifier_input_pin,
    input wire logic sleep_req,
    input wire logic wake_event,
    output logic core_clock,
    output logic peripheral_clock,
    output logic program_memory_clock,
    output logic core_release,
    output logic usu_start_detect_arm,
    output logic amp_enable,
    output logic [1:0] amp_range
);

    // Decodes fuse fields into start-up length, reset delay and validity.
    function automatic logic [4:0] csc_decode(input logic [3:0] src,
        input logic [1:0] sut);
        logic [4:0] r;
        r = {1'b1, SU_SHORT, DLY_NONE};
        if (src[SRC_XTAL_BIT])
        begin
            case ({src[0], sut})
                3'h0: r = {1'b1, SU_MID, DLY_SHORT};
                3'h1: r = {1'b1, SU_MID, DLY_LONG};
                3'h2: r = {1'b1, SU_1K, DLY_NONE};
                3'h3: r = {1'b1, SU_1K, DLY_SHORT};
                3'h4: r = {1'b1, SU_1K, DLY_LONG};
                3'h5: r = {1'b1, SU_16K, DLY_NONE};
                3'h6: r = {1'b1, SU_16K, DLY_SHORT};
                default: r = {1'b1, SU_16K, DLY_LONG};
            endcase
        end
        else if (src == SRC_EXT || src == SRC_RC4 || src == SRC_RC8 ||
            src == SRC_WDT)
        begin
            case (sut)
                2'h0: r = {1'b1, SU_SHORT, DLY_NONE};
                2'h1: r = {1'b1, SU_SHORT, DLY_SHORT};
                2'h2: r = {1'b1, SU_SHORT, DLY_LONG};
                default: r = {1'b0, SU_SHORT, DLY_NONE};
            endcase
        end
        else
        begin
            r = {1'b0, SU_SHORT, DLY_NONE};
        end
        return r;
    endfunction : csc_decode

    logic [3:0] src_s1_q, src_s2_q;
    logic [1:0] sut_s1_q, sut_s2_q;
    logic div8_s1_q, div8_s2_q;
    logic pin_s1_q, pin_s2_q, pin_s3_q;
    logic [3:0] src_q, src_d;
    logic [1:0] sut_q, sut_d;
    logic div8_q, div8_d;
    logic [1:0] su_q, su_d;
    logic [1:0] dly_q, dly_d;
    csc_state_t state_q, state_d;
    logic [16:0] cnt_q, cnt_d;
    logic [7:0] wdiv_q, wdiv_d, rdiv_q, rdiv_d, pre_q, pre_d;
    logic [1:0] mode_q, mode_d;
    logic [3:0] psc_q, psc_d;
    logic [31:0] prdata_q, prdata_d;
    logic pslverr_q, pslverr_d;
    logic core_q, core_d, per_q, per_d, run_q, run_d, arm_q, arm_d;
    logic osc_run, wdt_tick, rc_tick, pin_tick, sel_tick, sys_tick;
    logic [7:0] rc_div, pre_mask;
    logic [16:0] su_target, wdt_target;
    logic [4:0] dec;
    logic last_sel, last_wdt;

    // Two-stage synchronisers for fuse levels and the amplifier pin.
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            src_s1_q <= 4'hF;
            src_s2_q <= 4'hF;
            sut_s1_q <= 2'h3;
            sut_s2_q <= 2'h3;
            div8_s1_q <= 1'b1;
            div8_s2_q <= 1'b1;
            pin_s1_q <= 1'b0;
            pin_s2_q <= 1'b0;
            pin_s3_q <= 1'b0;
        end
        else
        begin
            src_s1_q <= clock_source_select;
            src_s2_q <= src_s1_q;
            sut_s1_q <= startup_time_select;
            sut_s2_q <= sut_s1_q;
            div8_s1_q <= divide_by_eight_fuse;
            div8_s2_q <= div8_s1_q;
            pin_s1_q <= amplifier_input_pin;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
        end
    end

    // Oscillator ticks; everything stops in power-down.
    always_comb
    begin
        osc_run = !(state_q == ST_SLEEP && mode_q == SLP_PDOWN);
        rc_div = (src_q == SRC_RC8) ? RC8_DIV : RC4_DIV;
        wdt_tick = osc_run && (wdiv_q == WDT_DIV - 8'h01);
        rc_tick = osc_run && (rdiv_q == rc_div - 8'h01);
        pin_tick = osc_run && pin_s2_q && !pin_s3_q;
        wdiv_d = wdt_tick ? 8'h00 : (osc_run ? wdiv_q + 8'h01 : wdiv_q);
        rdiv_d = (rc_tick || rdiv_q >= rc_div) ? 8'h00 :
            (osc_run ? rdiv_q + 8'h01 : rdiv_q);
        // Selected source drives the start-up count.
        if (src_q == SRC_WDT)
            sel_tick = wdt_tick;
        else if (src_q == SRC_RC4 || src_q == SRC_RC8)
            sel_tick = rc_tick;
        else
            sel_tick = pin_tick;
        pre_mask = 8'((9'h001 << psc_q) - 9'h001);
        sys_tick = sel_tick && ((pre_q & pre_mask) == pre_mask);
        pre_d = sel_tick ? pre_q + 8'h01 : pre_q;
    end

    // Targets for the selected-clock and watchdog counts.
    always_comb
    begin
        case (su_q)
            SU_SHORT: su_target = SU_SHORT_CYC;
            SU_MID: su_target = SU_MID_CYC;
            SU_1K: su_target = SU_1K_CYC;
            default: su_target = SU_LONG_CYC;
        endcase
        wdt_target = (dly_q == DLY_LONG) ? WDT_LONG_CYC : WDT_SHORT_CYC;
        last_sel = sel_tick && (cnt_q == su_target - 17'h00001);
        last_wdt = wdt_tick && (cnt_q == wdt_target - 17'h00001);
    end

    // Start-up sequencer: fuse capture, counts, run and sleep.
    always_comb
    begin
        state_d = state_q;
        cnt_d = cnt_q;
        src_d = src_q;
        sut_d = sut_q;
        div8_d = div8_q;
        su_d = su_q;
        dly_d = dly_q;
        dec = csc_decode(src_s2_q, sut_s2_q);
        case (state_q)
            ST_FUSE:
            begin
                cnt_d = cnt_q + 17'h00001;
                if (cnt_q == FUSE_SYNC_CYC)
                begin
                    src_d = src_s2_q;
                    sut_d = sut_s2_q;
                    div8_d = !div8_s2_q;
                    su_d = dec[3:2];
                    dly_d = dec[1:0];
                    cnt_d = 17'h00000;
                    state_d = dec[4] ? ST_SU : ST_HALT;
                end
            end
            ST_SU:
            begin
                cnt_d = sel_tick ? cnt_q + 17'h00001 : cnt_q;
                if (last_sel)
                begin
                    cnt_d = 17'h00000;
                    state_d = ST_FIX;
                end
            end
            ST_FIX:
            begin
                cnt_d = sel_tick ? cnt_q + 17'h00001 : cnt_q;
                if (sel_tick && cnt_q == DLY_FIX_CYC - 17'h00001)
                begin
                    cnt_d = 17'h00000;
                    state_d = (dly_q == DLY_NONE) ? ST_RUN : ST_WDT;
                end
            end
            ST_WDT:
            begin
                cnt_d = wdt_tick ? cnt_q + 17'h00001 : cnt_q;
                if (last_wdt)
                begin
                    cnt_d = 17'h00000;
                    state_d = ST_RUN;
                end
            end
            ST_RUN:
            begin
                cnt_d = 17'h00000;
                if (sleep_req)
                    state_d = ST_SLEEP;
            end
            ST_SLEEP:
            begin
                cnt_d = 17'h00000;
                if (wake_event)
                    state_d = (mode_q == SLP_PDOWN) ? ST_SU : ST_RUN;
            end
            ST_HALT: state_d = ST_HALT;
            default: state_d = ST_FUSE;
        endcase
    end

    // Domain gating; the flash domain follows the core domain.
    always_comb
    begin
        run_d = (state_d == ST_RUN) || (state_d == ST_SLEEP);
        core_d = (state_q == ST_RUN) && sys_tick;
        per_d = sys_tick && ((state_q == ST_RUN) ||
            (state_q == ST_SLEEP && mode_q == SLP_IDLE));
        arm_d = (state_q == ST_SLEEP) && (mode_q != SLP_IDLE);
    end

    // APB slave; read data and error are taken in the setup cycle.
    always_comb
    begin
        mode_d = mode_q;
        psc_d = psc_q;
        prdata_d = prdata_q;
        pslverr_d = pslverr_q;
        if (state_q == ST_FUSE && state_d != ST_FUSE)
            psc_d = div8_d ? PSC_DIV8 : PSC_DIV1;
        if (psel && !penable)
        begin
            prdata_d = 32'h00000000;
            pslverr_d = 1'b0;
            case (paddr)
                ADDR_CTRL: prdata_d[CTRL_MODE_LSB +: 2] = mode_q;
                ADDR_STAT:
                begin
                    prdata_d[STAT_SRC_LSB +: 4] = src_q;
                    prdata_d[STAT_SUT_LSB +: 2] = sut_q;
                    prdata_d[STAT_DIV8_BIT] = div8_q;
                    prdata_d[STAT_RUN_BIT] = run_q;
                    prdata_d[STAT_ERR_BIT] = (state_q == ST_HALT);
                    prdata_d[STAT_STATE_LSB +: 7] = state_q;
                end
                ADDR_PSC: prdata_d[3:0] = psc_q;
                default: pslverr_d = 1'b1;
            endcase
        end
        if (psel && penable && pwrite)
        begin
            if (paddr == ADDR_CTRL)
                mode_d = pwdata[CTRL_MODE_LSB +: 2];
            else if (paddr == ADDR_PSC)
                psc_d = (pwdata[3:0] > PSC_MAX) ? PSC_MAX : pwdata[3:0];
        end
    end

    // State registers.
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_q <= ST_FUSE;
            cnt_q <= 17'h00000;
            src_q <= 4'hF;
            sut_q <= 2'h3;
            div8_q <= 1'b0;
            su_q <= SU_SHORT;
            dly_q <= DLY_NONE;
            wdiv_q <= 8'h00;
            rdiv_q <= 8'h00;
            pre_q <= 8'h00;
            mode_q <= CTRL_RESET;
            psc_q <= PSC_DIV1;
            prdata_q <= 32'h00000000;
            pslverr_q <= 1'b0;
            core_q <= 1'b0;
            per_q <= 1'b0;
            run_q <= 1'b0;
            arm_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            src_q <= src_d;
            sut_q <= sut_d;
            div8_q <= div8_d;
            su_q <= su_d;
            dly_q <= dly_d;
            wdiv_q <= wdiv_d;
            rdiv_q <= rdiv_d;
            pre_q <= pre_d;
            mode_q <= mode_d;
            psc_q <= psc_d;
            prdata_q <= prdata_d;
            pslverr_q <= pslverr_d;
            core_q <= core_d;
            per_q <= per_d;
            run_q <= run_d;
            arm_q <= arm_d;
        end
    end

    // Outputs; the amplifier runs only for crystal sources when not off.
    assign prdata = prdata_q;
    assign pslverr = pslverr_q;
    assign pready = 1'b1;
    assign core_clock = core_q;
    assign program_memory_clock = core_q;
    assign peripheral_clock = per_q;
    assign core_release = run_q;
    assign usu_start_detect_arm = arm_q;
    assign amp_enable = src_q[SRC_XTAL_BIT] && osc_run && state_q != ST_HALT;
    assign amp_range = src_q[SRC_XTAL_BIT] ? src_q[2:1] : 2'h0;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    reserved_halts_a: assert property ((state_q == ST_FUSE &&
        state_d != ST_FUSE && !src_s2_q[3] && src_s2_q[0]) |=>
        state_q == ST_HALT) else $error("reserved source not halted");
    fuse_polarity_a: assert property ((state_q == ST_FUSE &&
        state_d == ST_SU) |=> (psc_q == (div8_s2_q ? PSC_DIV1 : PSC_DIV8)))
        else $error("prescale not set from fuse");
    wake_count_a: assert property ($rose(state_q == ST_FIX) |->
        $past(last_sel)) else $error("start-up ended early");
    wdt_delay_a: assert property ((state_q == ST_WDT &&
        $past(state_q) == ST_WDT && state_d == ST_RUN) |->
        cnt_q == wdt_target - 17'h00001) else $error("wdt delay");
    core_gate_a: assert property (core_clock |-> $past(state_q) == ST_RUN)
        else $error("core clock outside run");
    flash_follow_a: assert property (program_memory_clock == core_clock)
        else $error("flash clock differs");
    pdown_stop_a: assert property ((state_q == ST_SLEEP &&
        mode_q == SLP_PDOWN) |=> !peripheral_clock && !core_clock)
        else $error("clock in power-down");
    usu_arm_a: assert property ((state_q == ST_SLEEP && mode_q != SLP_IDLE)
        |=> usu_start_detect_arm) else $error("start detect off");
    release_gate_a: assert property (core_release |->
        (state_q == ST_RUN || state_q == ST_SLEEP))
        else $error("released too early");
    amp_range_a: assert property (src_q[SRC_XTAL_BIT] |->
        amp_range == src_q[2:1]) else $error("range wrong");

    run_reached_c: cover property (state_q == ST_WDT ##1 state_q == ST_RUN);
    wake_pdown_c: cover property (state_q == ST_SLEEP && mode_q == SLP_PDOWN
        ##1 state_q == ST_SU);
    idle_sleep_c: cover property (state_q == ST_SLEEP && peripheral_clock);
    halt_c: cover property (state_q == ST_HALT);

endmodule : csc_top

// ==== sim/tb_top.sv ====
// Self-checking testbench for the clock source and start-up controller.
`timescale 1ns/100ps
module tb_top
    import csc_pkg::*;
;
    localparam int SUL = 64;
    localparam int WS = 16;
    localparam int WL = 32;
    localparam int WT = int'(WDT_DIV);
    logic mclk, rst_b, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, e;
    logic [3:0] clock_source_select, c;
    logic [1:0] startup_time_select, amp_range, s;
    logic divide_by_eight_fuse, sleep_req, wake_event;
    logic amplifier_input_pin = 1'b0;
    logic [2:0] pin_cnt = 3'h0;
    logic core_clock, peripheral_clock, program_memory_clock, core_release;
    logic usu_start_detect_arm, amp_enable;
    int errors, n_compared, early_cnt, pm_diff, core_cnt, per_cnt;
    int cyc, ex, c0, p0;
    // Start-up table: fuses, start-up ticks, tick length, delay ticks.
    logic [3:0] t_src [12] = '{4'h8, 4'hA, 4'hC, 4'hE, 4'h9, 4'hB, 4'hD,
        4'hF, 4'h0, 4'h4, 4'h2, 4'h6};
    logic [1:0] t_sut [12] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0, 2'h1, 2'h2,
        2'h3, 2'h0, 2'h1, 2'h2, 2'h0};
    int t_su [12] = '{258, 258, 1024, 1024, 1024, SUL, SUL, SUL, 6, 6, 6, 6};
    int t_tick [12] = '{8, 8, 8, 8, 8, 8, 8, 8, 8, 3, 6, WT};
    int t_dly [12] = '{WS, WL, 0, WS, WL, 0, WS, WL, 0, WS, WL, 0};

    // Shortened long counts keep the run brief.
    csc_top #(
        .SU_LONG_CYC(17'(SUL)),
        .WDT_SHORT_CYC(17'(WS)),
        .WDT_LONG_CYC(17'(WL))
    ) i_dut (
        .mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr),
        .clock_source_select(clock_source_select),
        .startup_time_select(startup_time_select),
        .divide_by_eight_fuse(divide_by_eight_fuse),
        .amplifier_input_pin(amplifier_input_pin),
        .sleep_req(sleep_req), .wake_event(wake_event),
        .core_clock(core_clock), .peripheral_clock(peripheral_clock),
        .program_memory_clock(program_memory_clock),
        .core_release(core_release),
        .usu_start_detect_arm(usu_start_detect_arm),
        .amp_enable(amp_enable), .amp_range(amp_range)
    );

    // Free-running 25 MHz system clock.
    initial
    begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    // External clock on the amplifier pin, one cycle every 8 system clocks.
    always @(posedge mclk)
    begin
        pin_cnt <= pin_cnt + 3'h1;
        amplifier_input_pin <= pin_cnt[2];
    end

    // Counts enable pulses, and any pulse before the core is released.
    always @(posedge mclk)
    begin
        if (rst_b && core_release !== 1'b1 && (core_clock || peripheral_clock))
            early_cnt <= early_cnt + 1;
        if (core_clock !== program_memory_clock)
            pm_diff <= pm_diff + 1;
        if (core_clock === 1'b1)
            core_cnt <= core_cnt + 1;
        if (peripheral_clock === 1'b1)
            per_cnt <= per_cnt + 1;
    end

    // One APB transfer; waits for pready and takes the answer at that edge.
    task automatic apb(input logic wr, input logic [11:0] a,
        input logic [31:0] wd, output logic [31:0] q, output logic f);
        int n;
        n = 0;
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1 && n < 50)
        begin
            n++;
            @(posedge mclk);
        end
        q = prdata;
        f = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Resets with the given fuses and counts cycles until core release.
    task automatic boot(input logic [3:0] src, input logic [1:0] sut,
        input logic div8, input int lim);
        rst_b <= 1'b0;
        clock_source_select <= src;
        startup_time_select <= sut;
        divide_by_eight_fuse <= div8;
        repeat (4) @(posedge mclk);
        rst_b <= 1'b1;
        cyc = 0;
        while (core_release !== 1'b1 && cyc < lim)
        begin
            cyc++;
            @(posedge mclk);
        end
    endtask : boot

    // Counts edges until the next core clock pulse.
    task automatic wait_core();
        cyc = 0;
        do
        begin
            @(posedge mclk);
            cyc++;
        end
        while (core_clock !== 1'b1 && cyc < 5000);
    endtask : wait_core

    // Compares a design value exactly.
    task automatic check(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // Compares a measured cycle count against a window.
    task automatic check_rng(input string what, input int exp, input int got,
        input int tol);
        n_compared++;
        if (got < exp - tol || got > exp + tol)
        begin
            errors++;
            $display("ERROR %s expected %0d seen %0d", what, exp, got);
        end
    endtask : check_rng

    // Prints the verdict and ends the run.
    task automatic test_done();
        if (errors == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : test_done

    // Cuts the run short if the sequence hangs.
    initial
    begin
        repeat (120000) @(posedge mclk);
        errors++;
        test_done();
    end

    // Main sequence: start-up table, registers, refused fuses, sleep modes, prescale.
    initial
    begin
        rst_b = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        clock_source_select = 4'h2;
        startup_time_select = 2'h2;
        divide_by_eight_fuse = 1'b0;
        sleep_req = 1'b0;
        wake_event = 1'b0;
        repeat (20) @(posedge mclk);
        for (int i = 0; i < 12; i++)
        begin
            boot(t_src[i], t_sut[i], i[0], 40000);
            ex = (t_su[i] + 14) * t_tick[i] + t_dly[i] * WT;
            check_rng("startup", ex, cyc, 2 * t_tick[i] + WT + 20);
            apb(1'b0, ADDR_STAT, 32'h0, rd, err);
            e = {16'h0, 7'h10, 2'b01, ~i[0], t_sut[i], t_src[i]};
            check("stat", e, rd);
            apb(1'b0, ADDR_PSC, 32'h0, rd, err);
            check("psc", i[0] ? 32'h0 : 32'h3, rd);
            e = {29'h0, t_src[i][3], t_src[i][3] ? t_src[i][2:1] : 2'h0};
            check("amp", e, {29'h0, amp_enable, amp_range});
        end
        // Registers: reset value, unmapped place, read-only status.
        apb(1'b0, ADDR_CTRL, 32'h0, rd, err);
        check("ctrl", 32'h0, rd);
        apb(1'b0, 12'h00C, 32'h0, rd, err);
        check("unmapped", 32'h1, {rd[30:0], err});
        apb(1'b1, ADDR_STAT, 32'hFFFF_FFFF, rd, err);
        apb(1'b0, ADDR_STAT, 32'h0, rd, err);
        check("stat ro", 32'h0000_2086, rd);
        // Refused fuse codes halt with every clock stopped.
        for (int i = 0; i < 8; i++)
        begin
            c = 4'(i < 4 ? 2 * i + 1 : 2 * i - 8);
            s = i < 4 ? 2'h0 : 2'h3;
            boot(c, s, 1'b1, 600);
            apb(1'b0, ADDR_STAT, 32'h0, rd, err);
            check("halt", {16'h0, 7'h40, 3'b100, s, c}, rd);
        end
        // Sleep modes on a crystal source with no reset delay.
        boot(4'hB, 2'h1, 1'b1, 2000);
        for (int m = 0; m < 3; m++)
        begin
            apb(1'b1, ADDR_CTRL, 32'(m), rd, err);
            @(posedge mclk);
            sleep_req <= 1'b1;
            @(posedge mclk);
            sleep_req <= 1'b0;
            repeat (4) @(posedge mclk);
            c0 = core_cnt;
            p0 = per_cnt;
            repeat (64) @(posedge mclk);
            check("sleep core", 32'h0, 32'(core_cnt - c0));
            check("sleep per", 32'(m == 0), 32'(per_cnt != p0));
            check("arm", 32'(m != 0), 32'(usu_start_detect_arm));
            wake_event <= 1'b1;
            @(posedge mclk);
            wake_event <= 1'b0;
            wait_core();
            ex = m == 1 ? (SUL + 14) * 8 : 8;
            check_rng("wake", ex, cyc, m == 1 ? 30 : 10);
        end
        // Prescale: pulse spacing and clamping of large values.
        apb(1'b1, ADDR_PSC, 32'h2, rd, err);
        wait_core();
        wait_core();
        wait_core();
        check_rng("gap", 32, cyc, 1);
        apb(1'b1, ADDR_PSC, 32'h9, rd, err);
        apb(1'b0, ADDR_PSC, 32'h0, rd, err);
        check("psc clamp", 32'h8, rd);
        check("early", 32'h0, 32'(early_cnt));
        check("pm clock", 32'h0, 32'(pm_diff));
        test_done();
    end
endmodule : tb_top
